// file: verilog/gpioc_map.vh
// Register map, field masks and reset values of the port C register block.
// Assumes byte addressing on a 32-bit APB bus; offsets are low 16 address bits.
`ifndef GPIOC_MAP_VH
`define GPIOC_MAP_VH
`define GPIOC_DIR_OFS 16'h6080
`define GPIOC_LVL_OFS 16'h6090
`define GPIOC_LAT_OFS 16'h60a0
`define GPIOC_ODC_OFS 16'h60b0
`define GPIOC_ALIAS_WR 2'h0
`define GPIOC_ALIAS_CLR 2'h1
`define GPIOC_ALIAS_SET 2'h2
`define GPIOC_ALIAS_INV 2'h3
`define GPIOC_MASK_SMALL 16'hf000
`define GPIOC_MASK_LARGE 16'hf01e
`define GPIOC_DIR_RESET 16'hf01e
`define GPIOC_ODC_RESET 16'h0000
`define GPIOC_LAT_RESET 16'h0000
`endif

// file: verilog/gpioc_sync.v
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to the clock.
module gpioc_sync
(
  input wire clk,
  input wire rst_n,
  input wire [15:0] pin_in,
  output reg [15:0] pin_out
);
  reg [15:0] s1_reg;
  reg [15:0] s2_reg;
  reg [15:0] s3_reg;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 16'h0000;
      s2_reg <= 16'h0000;
      s3_reg <= 16'h0000;
      pin_out <= 16'h0000;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Only bits where stages two and three agree may change
      pin_out <= (s2_reg & ~(s2_reg ^ s3_reg)) | (pin_out & (s2_reg ^ s3_reg));
    end
  end
endmodule

// file: verilog/gpioc_top.v
// Port C register block: direction, pin level, output latch, open-drain control.
// Assumes an APB master on REF_CLK; pins are external and asynchronous.
//
// Design decision made here: the APB register port.
`include "gpioc_map.vh"
module gpioc_top
#(
  parameter LARGE = 1
)
(
  input wire REF_CLK,
  input wire RESETN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [31:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [15:0] PIN_IN,
  output reg [15:0] PIN_OUT,
  output reg [15:0] PIN_OE
);
  localparam [15:0] IMPL = LARGE ? `GPIOC_MASK_LARGE : `GPIOC_MASK_SMALL;

  reg rst_a_reg;
  reg rst_b_reg;
  wire rst_n = rst_b_reg;
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end
    else
    begin
      rst_a_reg <= 1'b1;
      rst_b_reg <= rst_a_reg;
    end
  end

  wire [15:0] pin_sync;
  gpioc_sync u_sync
  (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .pin_in(PIN_IN),
    .pin_out(pin_sync)
  );

  reg [15:0] pin_direction_reg;
  reg [15:0] output_latch_reg;
  reg [15:0] open_drain_ctrl_reg;
  reg [15:0] pin_level_reg;
  reg [15:0] pin_direction_next;
  reg [15:0] output_latch_next;
  reg [15:0] open_drain_ctrl_next;
  reg [15:0] pin_out_next;
  reg [15:0] pin_oe_next;
  reg [31:0] read_next;

  // Apply a plain write or a clear/set/invert alias to a register value
  function [15:0] alias_op;
    input [15:0] cur;
    input [15:0] wd;
    input [1:0] op;
    begin
      case (op)
        `GPIOC_ALIAS_WR: alias_op = wd;
        `GPIOC_ALIAS_CLR: alias_op = cur & ~wd;
        `GPIOC_ALIAS_SET: alias_op = cur | wd;
        `GPIOC_ALIAS_INV: alias_op = cur ^ wd;
        default: alias_op = cur;
      endcase
    end
  endfunction

  // Decode one register group: upper half zero, word aligned, same 16-byte group as the offset
  function reg_hit;
    input [31:0] addr;
    input [15:0] ofs;
    begin
      reg_hit = (addr[31:16] == 16'h0000) && (addr[15:4] == ofs[15:4]) && (addr[1:0] == 2'h0);
    end
  endfunction

  wire hit_dir = reg_hit(PADDR, `GPIOC_DIR_OFS);
  wire hit_lvl = reg_hit(PADDR, `GPIOC_LVL_OFS);
  wire hit_lat = reg_hit(PADDR, `GPIOC_LAT_OFS);
  wire hit_odc = reg_hit(PADDR, `GPIOC_ODC_OFS);
  wire hit = hit_dir | hit_lvl | hit_lat | hit_odc;
  wire [1:0] op = PADDR[3:2];
  // First access cycle: the request is taken here and answered at the next edge
  wire access_first = PSEL && PENABLE && !PREADY;
  // Ready stands, so this edge completes the transfer and a write lands on it
  wire wr = PSEL && PENABLE && PWRITE && PREADY && hit;
  wire [15:0] wd = PWDATA[15:0] & IMPL;

  always @*
  begin
    pin_direction_next = pin_direction_reg;
    if (wr && hit_dir)
    begin
      pin_direction_next = alias_op(pin_direction_reg, wd, op) & IMPL;
    end
  end

  // Writes to the level register land in the latch, as on a real port
  always @*
  begin
    output_latch_next = output_latch_reg;
    if (wr && (hit_lat || hit_lvl))
    begin
      output_latch_next = alias_op(output_latch_reg, wd, op) & IMPL;
    end
  end

  always @*
  begin
    open_drain_ctrl_next = open_drain_ctrl_reg;
    if (wr && hit_odc)
    begin
      open_drain_ctrl_next = alias_op(open_drain_ctrl_reg, wd, op) & IMPL;
    end
  end

  // Pins take the values of the same edge, so a write shows on them at once
  always @*
  begin
    pin_out_next = output_latch_next & ~open_drain_ctrl_next & IMPL;
    // Open-drain pins only ever drive low; a high is released to the pull-up
    pin_oe_next = ~pin_direction_next & IMPL & (~open_drain_ctrl_next | ~output_latch_next);
  end

  // Read data stands only with ready; at any other time the bus reads zero
  always @*
  begin
    read_next = 32'h00000000;
    if (access_first && !PWRITE && hit)
    begin
      if (hit_dir)
        read_next = {16'h0000, pin_direction_reg};
      else if (hit_lvl)
        read_next = {16'h0000, pin_level_reg};
      else if (hit_lat)
        read_next = {16'h0000, output_latch_reg};
      else
        read_next = {16'h0000, open_drain_ctrl_reg};
    end
  end

  // Direction resets to inputs so nothing is driven before software decides
  always @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_direction_reg <= `GPIOC_DIR_RESET & IMPL;
    end
    else
    begin
      pin_direction_reg <= pin_direction_next;
    end
  end

  // Latch resets to zero; software must write it before use
  always @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      output_latch_reg <= `GPIOC_LAT_RESET;
    end
    else
    begin
      output_latch_reg <= output_latch_next;
    end
  end

  always @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      open_drain_ctrl_reg <= `GPIOC_ODC_RESET;
    end
    else
    begin
      open_drain_ctrl_reg <= open_drain_ctrl_next;
    end
  end

  always @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_level_reg <= 16'h0000;
    end
    else
    begin
      pin_level_reg <= pin_sync & IMPL;
    end
  end

  // One wait state: ready rises at the edge ending the first access cycle and stands for one cycle
  always @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= access_first;
      PSLVERR <= access_first && !hit;
    end
  end

  always @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PRDATA <= 32'h00000000;
    end
    else
    begin
      PRDATA <= read_next;
    end
  end

  always @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PIN_OUT <= 16'h0000;
      PIN_OE <= 16'h0000;
    end
    else
    begin
      PIN_OUT <= pin_out_next;
      PIN_OE <= pin_oe_next;
    end
  end
endmodule

// file: verif/gpioc_checker.sv
// Port-level checks of the port C register block.
// Assumes it is bound into gpioc_top.
`include "gpioc_map.vh"
module gpioc_checker
#(
  parameter LARGE = 1
)
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [15:0] PIN_IN,
  input wire logic [15:0] PIN_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] M = LARGE ? `GPIOC_MASK_LARGE : `GPIOC_MASK_SMALL;
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  // Eight quiet cycles outlast the filter, so the level register has caught up
  sequence quiet_pins;
    (RESETN && $stable(PIN_IN)) [*8];
  endsequence
  sequence lvl_read;
    PREADY && !PWRITE && !PSLVERR && PADDR == 32'h6090;
  endsequence
  one_wait_a: assert property (PSEL && $rose(PENABLE) |=> PREADY) else $error("late answer");
  rdy_pulse_a: assert property (PREADY |=> !PREADY) else $error("answer too long");
  err_alone_a: assert property (PSLVERR |-> PREADY) else $error("stray error");
  hi_zero_a: assert property (PREADY |-> PRDATA[31:16] == 16'h0) else $error("upper bits set");
  unimpl_zero_a: assert property (PREADY |-> (PRDATA[15:0] & ~M) == 16'h0) else $error("unused bits set");
  oe_mask_a: assert property ((PIN_OE & ~M) == 16'h0) else $error("unused pin driven");
  addr_refuse_a: assert property (PREADY && PADDR[31:16] != 16'h0 |-> PSLVERR && PRDATA == 32'h0)
    else $error("bad address taken");
  lvl_track_a: assert property (quiet_pins ##0 lvl_read |-> PRDATA[15:0] == (PIN_IN & M))
    else $error("level differs from pins");
endmodule
bind gpioc_top gpioc_checker #(.LARGE(LARGE)) i_chk
(
  .REF_CLK(REF_CLK),
  .RESETN(RESETN),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .PIN_IN(PIN_IN),
  .PIN_OE(PIN_OE)
);

// file: verif/gpioc_pins.sv
// External circuitry on the port pins.
// Assumes a bench value drives every pin that the block releases.
module gpioc_pins
(
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext,
  output logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// file: verif/testbench.sv
// Register tests of the port C block over APB.
// Assumes both variants share one bus and each has its own pin model on the far side.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, err;
  logic PREADY_S, PSLVERR_S, err_s;
  logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, PRDATA_S, r, rs;
  logic [15:0] PIN_IN, PIN_OUT, PIN_OE, ext = 16'h5a5a, m = 16'hf01e;
  logic [15:0] PIN_IN_S, PIN_OUT_S, PIN_OE_S;
  logic [15:0] v = ((16'hf01e & ~16'h1002) | 16'h1000) ^ 16'h3008;
  logic [31:0] ofs [3] = '{32'h6080, 32'h60a0, 32'h60b0};
  int n_errors = 0, compares = 0, cyc = 0;
  always #12.5 REF_CLK = ~REF_CLK;
  gpioc_top #(.LARGE(1)) i_dut
  (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE)
  );
  // Small variant on the same bus; it answers in the same cycle as the large one
  gpioc_top #(.LARGE(0)) i_dut_small
  (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA_S), .PREADY(PREADY_S), .PSLVERR(PSLVERR_S), .PIN_IN(PIN_IN_S),
    .PIN_OUT(PIN_OUT_S), .PIN_OE(PIN_OE_S)
  );
  gpioc_pins i_pins (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext(ext), .pin_in(PIN_IN));
  gpioc_pins i_pins_s (.pin_out(PIN_OUT_S), .pin_oe(PIN_OE_S), .ext(ext), .pin_in(PIN_IN_S));
  task give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  // The request stands until the rising edge at which ready is seen high; data is taken there
  task apb(input logic w, input logic [31:0] a, d, output logic [31:0] rd);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    rs = PRDATA_S;
    err = PSLVERR;
    err_s = PSLVERR_S;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  always @(posedge REF_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (3) @(posedge REF_CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    apb(0, 32'h6080, 0, r);
    chk(r, {16'h0, m});
    chk(rs, 32'h0000f000);
    apb(0, 32'h60b0, 0, r);
    chk(r, 32'h0);
    chk(rs, 32'h0);
    apb(0, 32'h60a0, 0, r);
    chk(r & 32'hffff0fe1, 32'h0);
    chk(rs & 32'hffff0fff, 32'h0);
    $display("reset test done");
    foreach (ofs[i])
    begin
      apb(1, ofs[i], 32'hffffffff, r);
      apb(0, ofs[i], 0, r);
      chk(r, {16'h0, m});
      chk(rs, 32'h0000f000);
      apb(1, ofs[i] + 4, 32'h1002, r);
      apb(1, ofs[i] + 8, 32'h1000, r);
      apb(1, ofs[i] + 12, 32'h3008, r);
      apb(0, ofs[i], 0, r);
      chk(r, {16'h0, v});
      chk(rs, {16'h0, v & 16'hf000});
    end
    $display("alias test done");
    repeat (8) @(posedge REF_CLK);
    apb(0, 32'h6090, 0, r);
    chk(r, {16'h0, ext & v});
    chk(rs, {16'h0, ext & v & 16'hf000});
    apb(0, 32'h16080, 0, r);
    chk(r, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(0, 32'h6082, 0, r);
    chk(r, 32'h0);
    chk({31'h0, err_s}, 32'h1);
    $display("pin test done");
    apb(1, 32'h6080, 0, r);
    apb(1, 32'h60b0, 32'h1002, r);
    apb(1, 32'h60a0, 32'h9012, r);
    repeat (8) @(posedge REF_CLK);
    chk({16'h0, PIN_OUT}, 32'h8010);
    chk({16'h0, PIN_OE}, 32'he01c);
    chk({16'h0, PIN_OUT_S}, 32'h8000);
    chk({16'h0, PIN_OE_S}, 32'he000);
    apb(0, 32'h6090, 0, r);
    chk(r, 32'h9012);
    chk(rs, 32'h9000);
    apb(1, 32'h6094, 32'h8000, r);
    apb(0, 32'h60a0, 0, r);
    chk(r, 32'h1012);
    chk(rs, 32'h1000);
    $display("drive test done");
    give_verdict;
  end
endmodule
